// file: hdl/cc_pins_top.sv
// Overview of operation
// - request pin low edge starts its buffer
// - host strobe also starts a transmission
// - only error-free frames reach acceptance filters
// - full pin shows buffer state or level
// - interrupt pin gated by per-source enables
// - receive full status readable by host
// - request pins selectable as plain inputs
// - clock pin gives prescaled device clock
// - clock pin alternately marks frame start
// - one-shot mode never retries a message
// - standard frames filter first two bytes
// - two masks, six filters, 29 bits
// - two receive buffers, prioritised storage
// - three transmit buffers, priority and abort
// - serial port mode 0,0/1,1 up to 10 MHz
// - host commands reach every control bit
// - bit rate up to 1 Mb/s
// - reset pin is active low
// - each receive buffer owns one mask
`include "cc_consts.svh"
module cc_pins_top #(
	parameter int ID_W   = `CC_ID_W,
	parameter int NUM_TX = `CC_NUM_TX
) (
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	input  wire logic                 dev_reset_n_i,
	input  wire logic                 send_request_in_0_i,
	input  wire logic                 send_request_in_1_i,
	input  wire logic                 send_request_in_2_i,
	input  wire logic                 bus_rx_in_i,
	output logic                      bus_tx_out_o,
	output logic                      divided_clock_out_o,
	output logic                      rx_full_out_0_o,
	output logic                      rx_full_out_1_o,
	output logic                      int_n_o,
	input  wire logic [2:0]           rts_mode_i,
	output logic      [2:0]           rts_level_o,
	input  wire logic [2:0]           host_tx_req_i,
	input  wire logic [2:0]           host_abort_i,
	input  wire logic [5:0]           tx_prio_i,
	input  wire logic                 one_shot_i,
	output logic      [2:0]           tx_pending_o,
	input  wire logic [1:0]           bf_int_mode_i,
	input  wire logic [1:0]           bf_gp_level_i,
	input  wire logic [5:0]           int_en_i,
	input  wire logic [5:0]           flag_clr_i,
	output logic      [5:0]           flags_o,
	input  wire logic                 divided_clock_out_en_i,
	input  wire logic [1:0]           divided_clock_out_psc_i,
	input  wire logic                 sof_mode_i,
	input  wire logic [`CC_BRP_W-1:0] brp_i,
	input  wire cc_pkg::cc_accept_type accept_i,
	output logic                      bit_tick_o,
	output logic                      rx_bit_o,
	input  wire logic                 eng_tx_bit_i,
	output logic                      tx_start_o,
	output logic      [1:0]           tx_sel_o,
	input  wire logic                 tx_done_i,
	input  wire logic                 tx_fail_i,
	input  wire logic                 sof_i,
	input  wire cc_pkg::cc_frame_type frame_i,
	input  wire logic                 frame_valid_i,
	input  wire logic                 frame_err_i,
	output cc_pkg::cc_frame_type      rx_frame_o,
	output logic                      rx_store_o,
	output logic                      rx_buf_o,
	output logic      [2:0]           rx_hit_o
);
	import cc_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (ID_W != `CC_ID_W || NUM_TX != `CC_NUM_TX)
	begin : g_bad
		$error("cc_pins_top: widths fixed by package");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// highest priority pending buffer, ties to higher index
	function automatic logic [1:0] tx_pick(
		input logic [2:0] p,
		input logic [5:0] pr
	);
		logic [1:0] best;
		logic [2:0] bp;
		best = 2'h0;
		bp   = 3'h0;
		for (int i = 0; i < 3; i++)
		begin
			if (p[i] && {1'b1, pr[2*i+:2]} >= bp)
			begin
				best = i[1:0];
				bp   = {1'b1, pr[2*i+:2]};
			end
		end
		return best;
	endfunction

	// masked compare of one acceptance filter
	function automatic logic flt_hit(
		input logic [`CC_ID_W-1:0] key,
		input logic [`CC_ID_W-1:0] m,
		input logic [`CC_ID_W-1:0] f,
		input logic                fe,
		input logic                ke
	);
		return (((key ^ f) & m) == '0) && (fe == ke);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] s1_r, s2_r, s3_r, pin_r;
	wire  [4:0] pin_raw = {bus_rx_in_i, dev_reset_n_i,
		send_request_in_2_i, send_request_in_1_i, send_request_in_0_i};
	wire  [4:0] agree   = ~(s2_r ^ s3_r);
	wire  [4:0] pin_nxt = (s3_r & agree) | (pin_r & ~agree);

	// three stages, change taken when last two agree
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_r  <= `CC_PIN_INIT;
			s2_r  <= `CC_PIN_INIT;
			s3_r  <= `CC_PIN_INIT;
			pin_r <= `CC_PIN_INIT;
		end
		else
		begin
			s1_r  <= pin_raw;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			pin_r <= pin_nxt;
		end
	end

	// device reset from the filtered pin
	wire dev_rst = ~pin_r[`CC_PIN_RST];

	// ----------------------------------------
	// request pins
	// ----------------------------------------
	logic [2:0] rts_prev_r;
	wire  [2:0] rts_n   = pin_r[`CC_PIN_RTS0+:3];
	// falling edge in request mode only
	wire  [2:0] rts_req = rts_prev_r & ~rts_n & rts_mode_i;
	// host strobes arrive decoded from the serial port
	wire  [2:0] req_set = rts_req | host_tx_req_i;

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rts_prev_r  <= 3'h7;
			rts_level_o <= 3'h7;
		end
		else
		begin
			rts_prev_r  <= rts_n;
			rts_level_o <= rts_n;
		end
	end

	// ----------------------------------------
	// transmit sequencer
	// ----------------------------------------
	cc_state_type st_r, st_nxt;
	logic [2:0]   pend_r, abt_r, done_r;
	logic [1:0]   sel_r;
	wire  [2:0]   sel_dec   = 3'(3'h1 << sel_r);
	wire  [2:0]   busy_mask = (st_r != ST_IDLE) ? sel_dec : 3'h0;
	wire          tx_end    = (st_r == ST_BUSY) && (tx_done_i || tx_fail_i);
	wire          drop      = tx_done_i || one_shot_i || |(abt_r & sel_dec);
	wire  [2:0]   end_clr   = (tx_end && drop) ? sel_dec : 3'h0;
	wire  [2:0]   done_set  = (tx_end && tx_done_i) ? sel_dec : 3'h0;
	wire          fail_set  = tx_end && !tx_done_i && one_shot_i;
	// abort of an idle request is immediate, of the active one at its end
	wire  [2:0]   pend_nxt  = (pend_r & ~(host_abort_i & ~busy_mask) & ~end_clr)
		| req_set;
	wire  [2:0]   abt_nxt   = tx_end ? 3'h0 : (abt_r | (host_abort_i & busy_mask));

	// next state
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
			begin
				if (|pend_r)
				begin
					st_nxt = ST_START;
				end
			end
			ST_START: st_nxt = ST_BUSY;
			ST_BUSY:
			begin
				if (tx_done_i || tx_fail_i)
				begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_r   <= ST_IDLE;
			sel_r  <= 2'h0;
			pend_r <= 3'h0;
			abt_r  <= 3'h0;
		end
		else
		begin
			st_r   <= dev_rst ? ST_IDLE : st_nxt;
			pend_r <= dev_rst ? 3'h0 : pend_nxt;
			abt_r  <= dev_rst ? 3'h0 : abt_nxt;
			if (st_r == ST_IDLE)
			begin
				sel_r <= tx_pick(pend_r, tx_prio_i);
			end
		end
	end

	assign tx_start_o   = (st_r == ST_START);
	assign tx_sel_o     = sel_r;
	assign tx_pending_o = pend_r;

	// ----------------------------------------
	// acceptance filtering
	// ----------------------------------------
	wire [7:0] db0 = (frame_i.dlc != 4'h0) ? frame_i.data[0] : 8'h00;
	wire [7:0] db1 = (frame_i.dlc > 4'h1) ? frame_i.data[1] : 8'h00;
	wire       use_db = accept_i.byte_filt && !frame_i.ext && !frame_i.rtr;
	// standard frames put the two data bytes below the identifier
	wire [`CC_STD_LSB-1:0] std_tail = use_db ? {2'b00, db0, db1} : '0;
	wire [`CC_ID_W-1:0] key = frame_i.ext ? frame_i.id
		: {frame_i.id[`CC_ID_W-1:`CC_STD_LSB], std_tail};
	logic [5:0] hit;

	// each filter against the mask of its buffer
	always_comb
	begin
		for (int k = 0; k < `CC_NUM_FLT; k++)
		begin
			hit[k] = flt_hit(key, accept_i.mask[(k < `CC_FLT_BUF0) ? 0 : 1],
				accept_i.filt[k], accept_i.filt_ext[k], frame_i.ext);
		end
	end

	logic [1:0] full_r;
	logic       err_r;
	wire  good  = frame_valid_i && !frame_err_i;
	wire  hit0  = |hit[1:0];
	wire  hit1  = |hit[5:2];
	// buffer 0 first, overflow into buffer 1 when allowed
	wire  to0   = good && hit0 && !full_r[0];
	wire  roll  = good && hit0 && full_r[0] && accept_i.rollover;
	wire  to1   = !to0 && (roll || (good && hit1 && !hit0)) && !full_r[1];
	wire  ovf   = good && (hit0 || hit1) && !to0 && !to1;
	wire  [2:0] hit_idx = hit[0] ? 3'h0 : hit[1] ? 3'h1 : hit[2] ? 3'h2
		: hit[3] ? 3'h3 : hit[4] ? 3'h4 : 3'h5;
	wire  [1:0] full_set = {to1, to0};

	// received data and store strobe
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_frame_o <= '0;
			rx_store_o <= 1'b0;
			rx_buf_o   <= 1'b0;
			rx_hit_o   <= 3'h0;
		end
		else
		begin
			rx_store_o <= (to0 || to1) && !dev_rst;
			if (to0 || to1)
			begin
				rx_frame_o <= frame_i;
				rx_buf_o   <= to1;
				rx_hit_o   <= hit_idx;
			end
		end
	end

	// ----------------------------------------
	// status flags and interrupt pin
	// ----------------------------------------
	wire [5:0] src = {err_r, done_r, full_r};

	// sticky flags, a set wins over a clear
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			full_r  <= 2'h0;
			done_r  <= 3'h0;
			err_r   <= 1'b0;
			int_n_o <= 1'b1;
		end
		else if (dev_rst)
		begin
			full_r  <= 2'h0;
			done_r  <= 3'h0;
			err_r   <= 1'b0;
			int_n_o <= 1'b1;
		end
		else
		begin
			full_r  <= (full_r & ~flag_clr_i[`CC_SRC_RX0+:2]) | full_set;
			done_r  <= (done_r & ~flag_clr_i[`CC_SRC_TX0+:3]) | done_set;
			err_r   <= (err_r & ~flag_clr_i[`CC_SRC_ERR]) | ovf | fail_set;
			int_n_o <= ~|(src & int_en_i);
		end
	end

	assign flags_o = src;

	// ----------------------------------------
	// buffer full pins
	// ----------------------------------------
	wire [1:0] bf_n = ~((bf_int_mode_i & full_r) | (~bf_int_mode_i & bf_gp_level_i));

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_full_out_0_o <= 1'b1;
			rx_full_out_1_o <= 1'b1;
		end
		else
		begin
			rx_full_out_0_o <= bf_n[0];
			rx_full_out_1_o <= bf_n[1];
		end
	end

	// ----------------------------------------
	// clock output and frame start marker
	// ----------------------------------------
	logic [3:0] div_r;
	logic       sof_r;
	wire  [3:0] div_nxt = div_r + 4'h1;
	// marker from frame start to frame end
	wire        sof_nxt = sof_i || (sof_r && !frame_valid_i && !frame_err_i && !tx_end);
	wire        ck_nxt  = sof_mode_i ? sof_r : div_nxt[divided_clock_out_psc_i];

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_r               <= 4'h0;
			sof_r               <= 1'b0;
			divided_clock_out_o <= 1'b0;
		end
		else
		begin
			div_r               <= div_nxt;
			sof_r               <= sof_nxt && !dev_rst;
			divided_clock_out_o <= divided_clock_out_en_i && !dev_rst && ck_nxt;
		end
	end

	// ----------------------------------------
	// bit tick and bus pins
	// ----------------------------------------
	localparam logic [10:0] BIT_CYC = 11'(`CC_BIT_CYC);
	logic [10:0] tq_r;
	// one bit at the highest rate per prescale step
	wire  [10:0] tq_lim = 11'(({5'h0, brp_i} + 11'h1) * BIT_CYC - 11'h1);
	wire         tq_end = (tq_r >= tq_lim);

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tq_r         <= 11'h0;
			bit_tick_o   <= 1'b0;
			rx_bit_o     <= `CC_RECESSIVE;
			bus_tx_out_o <= `CC_RECESSIVE;
		end
		else
		begin
			tq_r         <= (tq_end || sof_i || dev_rst) ? 11'h0 : tq_r + 11'h1;
			bit_tick_o   <= tq_end && !dev_rst;
			rx_bit_o     <= pin_r[`CC_PIN_RX];
			bus_tx_out_o <= dev_rst ? `CC_RECESSIVE : eng_tx_bit_i;
		end
	end

endmodule // cc_pins_top

// file: hdl/cc_consts.svh
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define CC_ID_W      29
`define CC_NUM_TX    3
`define CC_NUM_RX    2
`define CC_NUM_FLT   6
`define CC_PRIO_W    2
`define CC_BRP_W     6
// ----------------------------------------
// field positions
// ----------------------------------------
`define CC_STD_LSB   18
`define CC_PIN_RTS0  0
`define CC_PIN_RST   3
`define CC_PIN_RX    4
`define CC_SRC_RX0   0
`define CC_SRC_TX0   2
`define CC_SRC_ERR   5
`define CC_FLT_BUF0  2
// ----------------------------------------
// reset values
// ----------------------------------------
`define CC_PIN_INIT  5'h1f
`define CC_RECESSIVE 1'b1
// ----------------------------------------
// timing
// ----------------------------------------
`define CC_CLK_NS    40
`define CC_BIT_NS    1000
`define CC_BIT_CYC   (`CC_BIT_NS / `CC_CLK_NS)
`define CC_SPI_KHZ   10000
`endif

// file: hdl/cc_pkg.sv
`include "cc_consts.svh"
package cc_pkg;
	// received or loaded message
	typedef struct packed {
		logic [`CC_ID_W-1:0] id;
		logic                ext;
		logic                rtr;
		logic [3:0]          dlc;
		logic [7:0][7:0]     data;
	} cc_frame_type;
	// acceptance configuration
	typedef struct packed {
		logic [`CC_NUM_RX-1:0][`CC_ID_W-1:0]  mask;
		logic [`CC_NUM_FLT-1:0][`CC_ID_W-1:0] filt;
		logic [`CC_NUM_FLT-1:0]               filt_ext;
		logic                                 byte_filt;
		logic                                 rollover;
	} cc_accept_type;
	// transmit sequencer
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_BUSY  = 2'b10
	} cc_state_type;
endpackage

// file: sim/cc_pins_checker.sv
// port-level relations of the pin logic
module cc_pins_checker (
	input wire logic       clock_i,
	input wire logic       reset_i,
	input wire logic       dev_reset_n_i,
	input wire logic       send_request_in_0_i,
	input wire logic       bus_tx_out_o,
	input wire logic       divided_clock_out_o,
	input wire logic       rx_full_out_0_o,
	input wire logic       int_n_o,
	input wire logic [2:0] rts_mode_i,
	input wire logic [2:0] rts_level_o,
	input wire logic [2:0] host_tx_req_i,
	input wire logic [5:0] int_en_i,
	input wire logic [5:0] flags_o,
	input wire logic       one_shot_i,
	input wire logic [2:0] tx_pending_o,
	input wire logic [1:0] bf_int_mode_i,
	input wire logic [1:0] bf_gp_level_i,
	input wire logic       divided_clock_out_en_i,
	input wire logic       sof_mode_i,
	input wire logic       eng_tx_bit_i,
	input wire logic       tx_start_o,
	input wire logic [1:0] tx_sel_o,
	input wire logic       tx_fail_i,
	input wire logic       frame_valid_i,
	input wire logic       frame_err_i,
	input wire logic       rx_store_o,
	input wire logic       rx_buf_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import cc_pkg::*;
	logic [5:0] dr_q;
	logic       dok;
	// device reset pin settled high for six edges
	assign dok = &dr_q;
	always_ff @(posedge clock_i or posedge reset_i)
		if (reset_i)
			dr_q <= 6'h00;
		else
			dr_q <= {dr_q[4:0], dev_reset_n_i};
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i || !dok);
	sequence s_req1;
		host_tx_req_i == 3'h2 && tx_pending_o == 3'h0 && !tx_start_o && rts_level_o == 3'h7;
	endsequence
	sequence s_start1;
		##2 tx_start_o && tx_sel_o == 2'h1;
	endsequence
	property p_tx_pin; bus_tx_out_o == $past(eng_tx_bit_i); endproperty
	property p_int; int_n_o == !$past(|(flags_o & int_en_i)); endproperty
	property p_full; rx_full_out_0_o == $past(bf_int_mode_i[0] ? !flags_o[0] : !bf_gp_level_i[0]); endproperty
	property p_err; frame_valid_i && frame_err_i |=> !rx_store_o; endproperty
	property p_store; rx_store_o |-> flags_o[rx_buf_o]; endproperty
	property p_host; s_req1 |-> s_start1; endproperty
	property p_rts; $fell(rts_level_o[0]) && rts_mode_i[0] |-> ##[0:2] tx_pending_o[0]; endproperty
	property p_filt; !send_request_in_0_i [*7] |-> !rts_level_o[0]; endproperty
	property p_one;
		tx_fail_i && one_shot_i && tx_pending_o == 3'h1 && host_tx_req_i == 3'h0 |=> !tx_pending_o[0] && flags_o[5];
	endproperty
	property p_start; tx_start_o |=> !tx_start_o && $stable(tx_sel_o); endproperty
	property p_clk; (!divided_clock_out_en_i && !sof_mode_i) [*3] |-> !divided_clock_out_o; endproperty
	a_tx_pin: assert property (p_tx_pin) else $error("tx pin differs");
	a_int: assert property (p_int) else $error("int pin wrong");
	a_full: assert property (p_full) else $error("full pin wrong");
	a_err: assert property (p_err) else $error("bad frame stored");
	a_store: assert property (p_store) else $error("store without flag");
	a_host: assert property (p_host) else $error("host start late");
	a_rts: assert property (p_rts) else $error("pin request lost");
	a_filt: assert property (p_filt) else $error("pin level stuck");
	a_one: assert property (p_one) else $error("one-shot retried");
	a_start: assert property (p_start) else $error("start pulse long");
	a_clk: assert property (p_clk) else $error("clock pin active");
endmodule // cc_pins_checker

bind cc_pins_top cc_pins_checker chk_i (.*);

// file: sim/cc_engine_model.sv
// protocol engine stand-in: frame of lat_i cycles, then done or fail
module cc_engine_model (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       tx_start_i,
	input  wire logic       fail_cmd_i,
	input  wire logic [3:0] lat_i,
	output logic            tx_done_o,
	output logic            tx_fail_o,
	output logic            tx_bit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	// bit toggles inside a frame, recessive between
	assign tx_bit_o = (cnt_r != 4'h0) ? cnt_r[0] : 1'b1;
	always_ff @(posedge clock_i or posedge reset_i)
		if (reset_i)
		begin
			cnt_r     <= 4'h0;
			tx_done_o <= 1'b0;
			tx_fail_o <= 1'b0;
		end
		else
		begin
			tx_done_o <= (cnt_r == 4'h1) && !fail_cmd_i;
			tx_fail_o <= (cnt_r == 4'h1) && fail_cmd_i;
			cnt_r     <= tx_start_i ? lat_i : cnt_r - 4'(cnt_r != 4'h0);
		end
endmodule // cc_engine_model

// file: sim/tb_cc_pins_top.sv
`include "cc_consts.svh"
module tb_cc_pins_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cc_pkg::*;
	logic clock_i, reset_i, dev_reset_n_i, send_request_in_0_i, send_request_in_1_i, send_request_in_2_i;
	logic bus_rx_in_i, bus_tx_out_o, divided_clock_out_o, rx_full_out_0_o, rx_full_out_1_o, int_n_o;
	logic one_shot_i, divided_clock_out_en_i, sof_mode_i, bit_tick_o, rx_bit_o, eng_tx_bit_i, tx_start_o;
	logic tx_done_i, tx_fail_i, sof_i, frame_valid_i, frame_err_i, rx_store_o, rx_buf_o, fail_cmd;
	logic [2:0] rts_mode_i, rts_level_o, host_tx_req_i, host_abort_i, tx_pending_o, rx_hit_o;
	logic [5:0] tx_prio_i, int_en_i, flag_clr_i, flags_o;
	logic [1:0] bf_int_mode_i, bf_gp_level_i, divided_clock_out_psc_i, tx_sel_o;
	logic [`CC_BRP_W-1:0] brp_i;
	logic [3:0] lat;
	logic [31:0] n;
	cc_accept_type accept_i;
	cc_frame_type frame_i, rx_frame_o;
	int seed, n_fail, tests_run, i, cyc;
	cc_pins_top dut (.*);
	cc_engine_model eng (.clock_i, .reset_i, .tx_start_i(tx_start_o), .fail_cmd_i(fail_cmd), .lat_i(lat),
		.tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i), .tx_bit_o(eng_tx_bit_i));
	// compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	task cyc_n(input int c); repeat (c) @(negedge clock_i); endtask
	task wait_start;
		for (i = 0; i < 40 && tx_start_o !== 1'b1; i++) cyc_n(1);
		chk("start_wait", 1'h1, tx_start_o);
	endtask
	task wait_idle;
		for (i = 0; i < 90 && tx_pending_o !== 3'h0; i++) cyc_n(1);
		chk("idle_wait", 3'h0, tx_pending_o);
	endtask
	task clr; flag_clr_i = 6'h3f; cyc_n(1); flag_clr_i = 6'h00; endtask
	// one frame in, store and target checked, then a spare cycle
	task put_frame(input logic st, input logic [2:0] h, input logic b);
		frame_valid_i = 1;
		cyc_n(1);
		frame_valid_i = 0;
		chk("flt_store", st, rx_store_o);
		if (st) chk("flt_hit", h, rx_hit_o);
		if (st) chk("flt_buf", b, rx_buf_o);
		cyc_n(1);
	endtask
	// cycles until s leaves v
	task automatic run_len(ref logic s, input logic v, output logic [31:0] c);
		c = 0;
		while (s === v && c < 2000) begin c++; cyc_n(1); end
	endtask
	// winner: highest priority, tie to higher index
	function logic [1:0] best(input logic [5:0] pr);
		best = 2'h0;
		for (int k = 1; k < 3; k++) if (pr[2*k+:2] >= pr[2*best+:2]) best = k[1:0];
	endfunction
	task results;
		$display("tests %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// clock and hang guard
	initial begin clock_i = 0; forever #20 clock_i = ~clock_i; end
	always @(posedge clock_i) begin cyc++; if (cyc == 30000) begin n_fail++; results; end end
	initial
	begin
		seed = 15844; n_fail = 0; tests_run = 0; cyc = 0;
		reset_i = 1; dev_reset_n_i = 1; bus_rx_in_i = 1; sof_i = 0; one_shot_i = 0;
		{send_request_in_2_i, send_request_in_1_i, send_request_in_0_i} = 3'h7;
		rts_mode_i = 3'h7; host_tx_req_i = 0; host_abort_i = 0; tx_prio_i = 0; flag_clr_i = 0;
		bf_int_mode_i = 2'h3; bf_gp_level_i = 0; int_en_i = 6'h3f; divided_clock_out_en_i = 0; divided_clock_out_psc_i = 0;
		sof_mode_i = 0; brp_i = 0; accept_i = '0; frame_i = '0; frame_valid_i = 0; frame_err_i = 0;
		fail_cmd = 0; lat = 4'h3;
		repeat (8) @(posedge clock_i);
		@(negedge clock_i) reset_i = 0;
		cyc_n(6);
		chk("bus_tx", 1'h1, bus_tx_out_o);
		chk("int_n", 1'h1, int_n_o);
		chk("rts_level", 3'h7, rts_level_o);
		$display("test reset done");
		// each buffer by host strobe, random latency
		for (int k = 0; k < 3; k++)
		begin
			lat = 4'h2 + 4'({$random(seed)} % 8);
			host_tx_req_i = 3'h1 << k; cyc_n(1); host_tx_req_i = 0;
			wait_start; chk("tx_sel", k, tx_sel_o);
			wait_idle; cyc_n(1); chk("done_flag", 1'h1, flags_o[2+k]);
		end
		// three at once, random priorities
		repeat (6)
		begin
			tx_prio_i = $random(seed); host_tx_req_i = 3'h7; cyc_n(1); host_tx_req_i = 0;
			wait_start; chk("prio", best(tx_prio_i), tx_sel_o); wait_idle;
		end
		// abort a waiting buffer while another sends
		tx_prio_i = 6'h0c; host_tx_req_i = 3'h3; cyc_n(1); host_tx_req_i = 0; wait_start;
		host_abort_i = 3'h1; cyc_n(1); host_abort_i = 0; chk("abort", 1'h0, tx_pending_o[0]); wait_idle;
		// failure: retry, then one-shot gives up
		clr; fail_cmd = 1; host_tx_req_i = 3'h1; cyc_n(1); host_tx_req_i = 0; wait_start; cyc_n(1);
		wait_start; chk("retry", 1'h1, tx_start_o); one_shot_i = 1; wait_idle;
		chk("one_shot", 2'h1, {tx_pending_o[0], flags_o[5]}); fail_cmd = 0; one_shot_i = 0;
		$display("test transmit done");
		// pin 0 requests, pin 1 plain input
		clr; rts_mode_i = 3'h5; send_request_in_0_i = 0; send_request_in_1_i = 0; cyc_n(8);
		chk("pin_req", 1'h1, tx_pending_o[0] | flags_o[2]);
		chk("pin_gp", 1'h0, tx_pending_o[1] | flags_o[3]);
		chk("pin_level", 3'h4, rts_level_o);
		send_request_in_0_i = 1; send_request_in_1_i = 1; wait_idle;
		// frames: bad one dropped, two stored, last refused
		clr; accept_i.rollover = 1; int_en_i = 6'h01;
		for (int k = 0; k < 4; k++)
		begin
			frame_i.id = 29'($random(seed)); frame_i.data = {$random(seed), $random(seed)}; frame_i.dlc = 4'h8;
			frame_valid_i = 1; frame_err_i = (k == 0); cyc_n(1); frame_valid_i = 0; frame_err_i = 0;
			chk("store", (k == 1 || k == 2), rx_store_o);
			if (k == 1 || k == 2) chk("rx_buf", k - 1, rx_buf_o);
			if (k == 1 || k == 2) chk("rx_id", frame_i.id, rx_frame_o.id);
			cyc_n(1);
		end
		cyc_n(1); chk("overrun", 1'h1, flags_o[5]);
		chk("full_pin", 1'h0, rx_full_out_0_o);
		chk("int_on", 1'h0, int_n_o);
		int_en_i = 6'h00; cyc_n(2); chk("int_mask", 1'h1, int_n_o);
		bf_int_mode_i = 2'h0; bf_gp_level_i = 2'h2; cyc_n(2);
		chk("gp_pins", 2'h1, {rx_full_out_1_o, rx_full_out_0_o});
		clr; cyc_n(1); chk("flags_clr", 6'h00, flags_o);
		// filters: full masks, buffer 1 filter, a miss, then data byte key
		accept_i.mask = '1; accept_i.filt_ext = 6'h08;
		for (int k = 0; k < 6; k++) accept_i.filt[k] = 29'($random(seed));
		frame_i.ext = 1; frame_i.id = accept_i.filt[3]; put_frame(1'b1, 3'h3, 1'b1);
		frame_i.id[0] = ~frame_i.id[0]; put_frame(1'b0, 3'h0, 1'b0);
		clr; accept_i.byte_filt = 1; frame_i.ext = 0;
		accept_i.filt[4] = {frame_i.id[`CC_ID_W-1:`CC_STD_LSB], 2'h0, frame_i.data[0], frame_i.data[1]};
		put_frame(1'b1, 3'h4, 1'b1);
		frame_i.data[1][0] = ~frame_i.data[1][0]; put_frame(1'b0, 3'h0, 1'b0);
		accept_i = '0;
		$display("test receive done");
		// clock pin prescaler, every setting
		divided_clock_out_en_i = 1;
		for (int k = 0; k < 4; k++)
		begin
			divided_clock_out_psc_i = k[1:0]; cyc_n(40);
			run_len(divided_clock_out_o, 1'b1, n); run_len(divided_clock_out_o, 1'b0, n);
			run_len(divided_clock_out_o, 1'b1, n);
			chk("clk_high", 32'h1 << k, n);
		end
		divided_clock_out_en_i = 0; cyc_n(4); chk("clk_off", 1'h0, divided_clock_out_o);
		// bit tick spacing
		brp_i = 6'({$random(seed)} % 4); cyc_n(200);
		run_len(bit_tick_o, 1'b0, n); run_len(bit_tick_o, 1'b1, n); run_len(bit_tick_o, 1'b0, n);
		chk("bit_tick", (brp_i + 1) * `CC_BIT_CYC - 1, n);
		bus_rx_in_i = 0; cyc_n(6); chk("rx_bit", 1'h0, rx_bit_o);
		bus_rx_in_i = 1; cyc_n(6); chk("rx_idle", 1'h1, rx_bit_o);
		// frame start marker
		divided_clock_out_en_i = 1; sof_mode_i = 1; sof_i = 1; cyc_n(1); sof_i = 0; cyc_n(2);
		chk("sof", 1'h1, divided_clock_out_o);
		$display("test clocks done");
		// device reset pin mid-transmission
		lat = 4'hf; host_tx_req_i = 3'h4; cyc_n(1); host_tx_req_i = 0; wait_start;
		dev_reset_n_i = 0; cyc_n(6);
		chk("dev_rst", 3'h1, {tx_pending_o, bus_tx_out_o});
		chk("dev_rst_clk", 1'h0, divided_clock_out_o);
		dev_reset_n_i = 1; cyc_n(6);
		host_tx_req_i = 3'h1; cyc_n(1); host_tx_req_i = 0; wait_start;
		chk("after_rst", 2'h0, tx_sel_o); wait_idle;
		$display("test device reset done");
		results;
	end
endmodule // tb_cc_pins_top
